/* core/sac_top.sv */
// Purpose: Control of a 10-bit successive-approximation converter
// Assumes: Analog front end supplies a comparator decision each bit period
// Notes:   APB register access, level interrupt output
//
// Contract
// R1 - Produce 10-bit result by successive approximation into readable result pair
// R2 - Six-bit channel field routes one input to sample-and-hold
// R3 - Channel selector offers temperature, DAC, fixed reference and ground
// R4 - Completion raises interrupt usable to wake from sleep
// R5 - Two-bit positive reference field: pin, supply, 2.048V, 4.096V
// R6 - One bit chooses negative reference pin or ground
// R7 - Three-bit clock field selects divide 2 to 64 or RC oscillator
// R8 - One bit per period; whole conversion takes twelve periods
// R9 - Software picks RC oscillator for conversions during sleep
// R10 - Non-RC conversion clock derives from system clock
// R11 - Software picks divider meeting the bit period specification
// R12 - Software waits after channel change before next conversion
// R13 - Software should select ground before stepping to lower voltage
// R14 - Writing start while enabled begins a conversion
// R15 - Completion clears start, sets done flag, updates both results
// R16 - Early stop writes partial result, filling with last converted bit; a stop in the lead period keeps the old result
// R17 - Done flag set on every completion regardless of enable
// R18 - Bits resolve most significant first, one per period

`timescale 1ns/1ps

module sac_top #(
  parameter int RES_W = sac_pkg::RES_W
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog front end
  input  wire logic        rc_osc,
  input  wire logic        cmp_out,
  output logic [5:0]       channel_select,
  output logic [1:0]       pos_ref_select,
  output logic             neg_ref_select,
  output logic             conv_enable,
  output logic             sample_hold,
  output logic [RES_W-1:0] dac_trial,
  // Interrupt
  output logic             irq
);

  sac_tick_if tk ();

  sac_pkg::sac_state_t st_r, st_nxt;
  logic [7:0]       c0_r, c0_nxt;
  logic [7:0]       c1_r, c1_nxt;
  logic [RES_W-1:0] sar_r, sar_nxt;
  logic [RES_W-1:0] res_r, res_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic [3:0]       bit_r, bit_nxt;
  logic             lastbit_r, lastbit_nxt;
  logic [sac_pkg::ST_W-1:0] stat_r, stat_nxt, ien_r, ien_nxt;
  logic [31:0]      rd_r, rd_nxt;
  logic [2:0]       cmp_sync_r;
  logic             cmp_lvl_r, cmp_lvl_nxt;
  logic             wr, rd, go, on, done_ev;
  logic [RES_W-1:0] fill;
  logic [15:0]      res_fmt;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign on = c0_r[sac_pkg::C0_ON];
  assign go = c0_r[sac_pkg::C0_GO];

  sac_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk)
  );

  assign tk.sel    = c1_r[sac_pkg::C1_CS +: 3]; // R7
  assign tk.rc_raw = rc_osc;
  assign tk.run    = (st_r != sac_pkg::SAC_IDLE);

  // Partial result: unresolved low bits copy last resolved bit
  always_comb begin
    fill = sar_r;
    for (int i = 0; i < RES_W; i++) begin
      if (i < int'(bit_r)) begin
        fill[i] = lastbit_r; // R16
      end
    end
  end

  // Sequencer
  always_comb begin
    st_nxt      = st_r;
    sar_nxt     = sar_r;
    res_nxt     = res_r;
    cnt_nxt     = cnt_r;
    bit_nxt     = bit_r;
    lastbit_nxt = lastbit_r;
    done_ev     = 1'b0;
    cmp_lvl_nxt = cmp_lvl_r;
    if (cmp_sync_r[2] == cmp_sync_r[1]) begin
      cmp_lvl_nxt = cmp_sync_r[2];
    end
    c0_nxt      = c0_r;
    c1_nxt      = c1_r;
    if (wr && paddr == sac_pkg::OFF_CTRL0) begin
      c0_nxt = pwdata[7:0];
    end
    if (wr && paddr == sac_pkg::OFF_CTRL1) begin
      c1_nxt = pwdata[7:0];
    end
    case (st_r)
      sac_pkg::SAC_IDLE: begin
        if (go && on) begin
          st_nxt  = sac_pkg::SAC_LEAD; // R14
          cnt_nxt = 4'h0;
          bit_nxt = 4'(RES_W);
          sar_nxt = '0;
        end
      end
      sac_pkg::SAC_LEAD: begin
        if (tk.tick) begin
          cnt_nxt = cnt_r + 4'h1;
          st_nxt  = sac_pkg::SAC_BITS;
          sar_nxt = {1'b1, {(RES_W-1){1'b0}}};
        end
      end
      sac_pkg::SAC_BITS: begin
        if (tk.tick) begin
          cnt_nxt = cnt_r + 4'h1;
          sar_nxt[bit_r-4'h1] = cmp_lvl_nxt; // R18
          lastbit_nxt         = cmp_lvl_nxt;
          bit_nxt             = bit_r - 4'h1;
          if (bit_r > 4'h1) begin
            sar_nxt[bit_r-4'h2] = 1'b1; // R1
          end else begin
            st_nxt = sac_pkg::SAC_TAIL;
          end
        end
      end
      sac_pkg::SAC_TAIL: begin
        if (tk.tick && cnt_r + 4'h1 >= sac_pkg::CONV_PERIODS) begin // R8
          st_nxt  = sac_pkg::SAC_IDLE;
          res_nxt = sar_r; // R15
          c0_nxt[sac_pkg::C0_GO] = 1'b0; // R15
          done_ev = 1'b1;
        end else if (tk.tick) begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      default: st_nxt = sac_pkg::SAC_IDLE;
    endcase
    if (st_r != sac_pkg::SAC_IDLE && !done_ev && (!c0_nxt[sac_pkg::C0_GO] || !on)) begin
      st_nxt  = sac_pkg::SAC_IDLE;
      res_nxt = (st_r == sac_pkg::SAC_LEAD) ? res_r : fill; // R16
      done_ev = 1'b0;
    end
  end

  // Result formatting and status
  always_comb begin
    if (c1_r[sac_pkg::C1_FM]) begin
      res_fmt = {6'h00, res_r};
    end else begin
      res_fmt = {res_r, 6'h00};
    end
    stat_nxt = stat_r;
    ien_nxt  = ien_r;
    if (wr && paddr == sac_pkg::OFF_ICLR) begin
      stat_nxt = stat_r & ~pwdata[sac_pkg::ST_W-1:0];
    end
    if (wr && paddr == sac_pkg::OFF_IEN) begin
      ien_nxt = pwdata[sac_pkg::ST_W-1:0];
    end
    if (done_ev) begin
      stat_nxt[sac_pkg::ST_DONE] = 1'b1; // R17
    end
    rd_nxt = rd_r;
    if (rd) begin
      case (paddr)
        sac_pkg::OFF_CTRL0:  rd_nxt = {24'h000000, c0_r};
        sac_pkg::OFF_CTRL1:  rd_nxt = {24'h000000, c1_r};
        sac_pkg::OFF_RES_HI: rd_nxt = {24'h000000, res_fmt[15:8]}; // R1
        sac_pkg::OFF_RES_LO: rd_nxt = {24'h000000, res_fmt[7:0]};
        sac_pkg::OFF_STAT:   rd_nxt = {31'h00000000, stat_r};
        sac_pkg::OFF_IEN:    rd_nxt = {31'h00000000, ien_r};
        default:             rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= sac_pkg::SAC_IDLE;
      c0_r       <= 8'h00;
      c1_r       <= 8'h00;
      sar_r      <= '0;
      res_r      <= '0;
      cnt_r      <= 4'h0;
      bit_r      <= 4'h0;
      lastbit_r  <= 1'b0;
      stat_r     <= '0;
      ien_r      <= '0;
      rd_r       <= 32'h00000000;
      cmp_sync_r <= 3'h0;
      cmp_lvl_r  <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      c0_r       <= c0_nxt;
      c1_r       <= c1_nxt;
      sar_r      <= sar_nxt;
      res_r      <= res_nxt;
      cnt_r      <= cnt_nxt;
      bit_r      <= bit_nxt;
      lastbit_r  <= lastbit_nxt;
      stat_r     <= stat_nxt;
      ien_r      <= ien_nxt;
      rd_r       <= rd_nxt;
      cmp_sync_r <= {cmp_sync_r[1:0], cmp_out};
      cmp_lvl_r  <= cmp_lvl_nxt;
    end
  end

  // Outputs
  assign prdata         = rd_r;
  assign pready         = 1'b1;
  assign pslverr        = 1'b0;
  assign channel_select = c0_r[sac_pkg::C0_CHS +: sac_pkg::CHS_W]; // R2 R3
  assign pos_ref_select = c1_r[sac_pkg::C1_PREF +: 2]; // R5
  assign neg_ref_select = c1_r[sac_pkg::C1_NREF]; // R6
  assign conv_enable    = on;
  assign sample_hold    = (st_r == sac_pkg::SAC_IDLE) || (st_r == sac_pkg::SAC_LEAD);
  assign dac_trial      = sar_r;
  assign irq            = |(stat_r & ien_r); // R4

endmodule // sac_top

/* core/sac_pkg.sv */
// Purpose: Shared constants and types for the SAR converter control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses

package sac_pkg;

  localparam int RES_W = 10;
  localparam int CNT_W = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0  = 8'h00;
  localparam logic [7:0] OFF_CTRL1  = 8'h04;
  localparam logic [7:0] OFF_RES_HI = 8'h08;
  localparam logic [7:0] OFF_RES_LO = 8'h0C;
  localparam logic [7:0] OFF_STAT   = 8'h10;
  localparam logic [7:0] OFF_IEN    = 8'h14;
  localparam logic [7:0] OFF_ICLR   = 8'h18;

  // Control 0 field positions
  localparam int C0_ON   = 0;
  localparam int C0_GO   = 1;
  localparam int C0_CHS  = 2;
  localparam int CHS_W   = 6;

  // Control 1 field positions
  localparam int C1_PREF = 0;
  localparam int C1_NREF = 2;
  localparam int C1_CS   = 4;
  localparam int C1_FM   = 7;

  // Channel codes for internal sources
  localparam logic [5:0] CH_VSS  = 6'h3C;
  localparam logic [5:0] CH_TEMP = 6'h3D;
  localparam logic [5:0] CH_DAC  = 6'h3E;
  localparam logic [5:0] CH_FVR  = 6'h3F;

  // Positive reference codes
  localparam logic [1:0] PREF_VDD  = 2'h0;
  localparam logic [1:0] PREF_PIN  = 2'h2;
  localparam logic [1:0] PREF_F2V  = 2'h1;
  localparam logic [1:0] PREF_F4V  = 2'h3;

  // Conversion clock codes; x11 selects the RC oscillator
  localparam logic [2:0] CS_DIV2  = 3'h0;
  localparam logic [2:0] CS_DIV4  = 3'h4;
  localparam logic [2:0] CS_DIV8  = 3'h1;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC    = 2'h3;

  // Sequence length in bit periods
  localparam logic [CNT_W-1:0] CONV_PERIODS = 4'hC;
  localparam logic [CNT_W-1:0] LEAD_PERIODS = 4'h1;

  // Status bits
  localparam int ST_DONE = 0;
  localparam int ST_W    = 1;

  typedef enum logic [1:0] {SAC_IDLE, SAC_LEAD, SAC_BITS, SAC_TAIL} sac_state_t;

endpackage

/* core/sac_tick_if.sv */
// Purpose: Bit-period tick carrier between divider and sequencer
// Assumes: Single clock domain
// Notes:   None

`timescale 1ns/1ps

interface sac_tick_if;
  logic [2:0] sel;
  logic       rc_raw;
  logic       run;
  logic       tick;
  modport src (input sel, input rc_raw, input run, output tick);
  modport dst (output sel, output rc_raw, output run, input tick);
endinterface

/* core/sac_clkdiv.sv */
// Purpose: Bit-period tick generator from system clock or RC oscillator
// Assumes: RC oscillator is asynchronous and slower than pclk
// Notes:   RC input passes three flops; edge counts when last two agree

`timescale 1ns/1ps

module sac_clkdiv (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Tick carrier
  sac_tick_if.src   tk
);

  logic [5:0] div_r, div_nxt;
  logic [2:0] sync_r, sync_nxt;
  logic       rc_lvl_r, rc_lvl_nxt;
  logic [5:0] last;
  logic       tick_c;

  always_comb begin
    case (tk.sel)
      sac_pkg::CS_DIV2:  last = 6'h01;
      sac_pkg::CS_DIV4:  last = 6'h03;
      sac_pkg::CS_DIV8:  last = 6'h07;
      sac_pkg::CS_DIV16: last = 6'h0F;
      sac_pkg::CS_DIV32: last = 6'h1F;
      sac_pkg::CS_DIV64: last = 6'h3F;
      default:           last = 6'h01;
    endcase
  end

  always_comb begin
    sync_nxt   = {sync_r[1:0], tk.rc_raw};
    rc_lvl_nxt = rc_lvl_r;
    if (sync_r[2] == sync_r[1]) begin
      rc_lvl_nxt = sync_r[2];
    end
    div_nxt = 6'h00;
    tick_c  = 1'b0;
    if (tk.sel[1:0] == sac_pkg::CS_RC) begin
      tick_c = tk.run && rc_lvl_nxt && !rc_lvl_r; // R7
    end else if (tk.run) begin
      if (div_r == last) begin
        tick_c = 1'b1;
      end else begin
        div_nxt = div_r + 6'h01; // R10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r    <= 6'h00;
      sync_r   <= 3'h0;
      rc_lvl_r <= 1'b0;
    end else begin
      div_r    <= div_nxt;
      sync_r   <= sync_nxt;
      rc_lvl_r <= rc_lvl_nxt;
    end
  end

  assign tk.tick = tick_c;

endmodule // sac_clkdiv

/* verif/sac_asserts.sv */
// Purpose: Port checks for the converter control block
// Assumes: Clock code steady during a conversion
// Notes:   Bound to sac_top
`timescale 1ns/1ps
module sac_asserts #(parameter int RES_W = 10) (
  input wire logic             pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [5:0]       channel_select,
  input wire logic [1:0]       pos_ref_select,
  input wire logic             neg_ref_select, conv_enable, sample_hold, irq,
  input wire logic [RES_W-1:0] dac_trial
);
  logic        wr, wr0, wr1, ab_r;
  logic [2:0]  cs_r;
  logic [10:0] lo_r;
  assign wr  = psel && penable && pwrite;
  assign wr0 = wr && paddr == sac_pkg::OFF_CTRL0;
  assign wr1 = wr && paddr == sac_pkg::OFF_CTRL1;
  // Clock code, abort seen, cycles out of sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_r <= 3'h0;
      ab_r <= 1'b0;
      lo_r <= 11'h000;
    end else begin
      cs_r <= wr1 ? pwdata[6:4] : cs_r;
      ab_r <= !sample_hold && (ab_r || wr0);
      lo_r <= sample_hold ? 11'h000 : lo_r + 11'h001;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_chan_follow: assert property (wr0 |=> channel_select == $past(pwdata[7:2]))
    else $error("channel wrong");
  a_pref_follow: assert property (wr1 |=> pos_ref_select == $past(pwdata[1:0]))
    else $error("pos ref wrong");
  a_nref_follow: assert property (wr1 |=> neg_ref_select == $past(pwdata[2]))
    else $error("neg ref wrong");
  a_on_follow: assert property (wr0 |=> conv_enable == $past(pwdata[0]))
    else $error("enable wrong");
  a_go_starts: assert property (wr0 && pwdata[1:0] == 2'h3 && sample_hold
    |-> ##[1:200] !sample_hold) else $error("no start");
  a_msb_first: assert property ($fell(sample_hold)
    |-> ##[0:1] dac_trial == {1'b1, {(RES_W-1){1'b0}}}) else $error("first trial wrong");
  a_one_step: assert property (!sample_hold && !$past(sample_hold) && $changed(dac_trial)
    |-> $countones(dac_trial ^ $past(dac_trial)) <= 2) else $error("trial jump");
  a_tad_count: assert property ($rose(sample_hold) && !ab_r && cs_r[1:0] != 2'h3
    |-> lo_r == 11 * (2 << {cs_r[1:0], cs_r[2]})) else $error("period count wrong");
  a_irq_drop: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("irq fell alone");
  c_irq: cover property ($rose(irq));
  c_start: cover property ($fell(sample_hold));
  c_abort: cover property (wr0 && !pwdata[1] && !sample_hold);
endmodule // sac_asserts
bind sac_top sac_asserts #(.RES_W(RES_W)) u_chk (
  .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite),
  .paddr (paddr), .pwdata (pwdata), .channel_select (channel_select),
  .pos_ref_select (pos_ref_select), .neg_ref_select (neg_ref_select),
  .conv_enable (conv_enable), .sample_hold (sample_hold), .irq (irq),
  .dac_trial (dac_trial)
);

/* verif/sac_afe_model.sv */
// Purpose: Analog front end: sample, hold, compare
// Assumes: Ideal comparator
// Notes:   RC oscillator runs free
`timescale 1ns/1ps
module sac_afe_model #(parameter int RC_HALF = 103) (
  input wire logic       pclk, sample_hold,
  input wire logic [9:0] dac_trial, vin,
  output logic           cmp_out, rc_osc
);
  logic [9:0] held_r;
  initial rc_osc = 1'b0;
  always #(RC_HALF) rc_osc = ~rc_osc;
  // Track input while sampling, hold otherwise
  always @(posedge pclk) begin
    if (sample_hold) held_r <= vin;
  end
  assign cmp_out = held_r >= dac_trial;
endmodule // sac_afe_model

/* verif/test_sar_adc_conversion_control.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Ideal front end, zero-wait APB
// Notes:   One task per scenario
`timescale 1ns/1ps
module test_sar_adc_conversion_control;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  vin = 10'h000, dac_trial;
  logic [5:0]  channel_select;
  logic [1:0]  pos_ref_select;
  logic        pready, pslverr, rc_osc, cmp_out, neg_ref_select, conv_enable, sample_hold, irq;
  logic [2:0]  cs_l [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int          n_fail = 0, n_compared = 0;
  sac_top DUT (
    .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable), .pwrite (pwrite),
    .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .pready (pready),
    .pslverr (pslverr), .rc_osc (rc_osc), .cmp_out (cmp_out),
    .channel_select (channel_select), .pos_ref_select (pos_ref_select),
    .neg_ref_select (neg_ref_select), .conv_enable (conv_enable),
    .sample_hold (sample_hold), .dac_trial (dac_trial), .irq (irq)
  );
  sac_afe_model AFE (
    .pclk (pclk), .sample_hold (sample_hold), .dac_trial (dac_trial), .vin (vin),
    .cmp_out (cmp_out), .rc_osc (rc_osc)
  );
  always #5 pclk = ~pclk;
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    chk(32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(e, rd);
  endtask
  task t_regs;
    rdc(sac_pkg::OFF_STAT, 32'h0);
    rdc(8'h1C, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(sac_pkg::OFF_CTRL0, 1'b1, {24'h0, sac_pkg::CH_VSS + 6'(i), 2'h0});
      apb(sac_pkg::OFF_CTRL1, 1'b1, {29'h0, i[0], i[1:0]});
      @(negedge pclk);
      chk({26'h0, sac_pkg::CH_VSS + 6'(i)}, {26'h0, channel_select});
      chk({30'h0, i[1:0]}, {30'h0, pos_ref_select});
      chk({31'h0, i[0]}, {31'h0, neg_ref_select});
    end
    $display("regs done");
  endtask
  task t_conv(input logic [2:0] cs, input logic [9:0] v, input logic ie);
    int k;
    vin <= v;
    apb(sac_pkg::OFF_CTRL1, 1'b1, {25'h0, cs, 4'h0});
    apb(sac_pkg::OFF_IEN, 1'b1, {31'h0, ie});
    apb(sac_pkg::OFF_CTRL0, 1'b1, {24'h0, sac_pkg::CH_VSS, 2'h0});
    apb(sac_pkg::OFF_CTRL0, 1'b1, 32'h1);
    repeat (4) @(posedge pclk);
    apb(sac_pkg::OFF_CTRL0, 1'b1, 32'h3);
    k = 0;
    do begin
      apb(sac_pkg::OFF_STAT, 1'b0, 32'h0);
      k++;
    end while (rd[0] !== 1'b1 && k < 400);
    chk(32'h1, rd);
    chk({31'h0, ie}, {31'h0, irq});
    if (cs != 3'h0) begin
      rdc(sac_pkg::OFF_RES_HI, {24'h0, v[9:2]});
      rdc(sac_pkg::OFF_RES_LO, {24'h0, v[1:0], 6'h0});
    end
    rdc(sac_pkg::OFF_CTRL0, 32'h1);
    apb(sac_pkg::OFF_ICLR, 1'b1, 32'h1);
    rdc(sac_pkg::OFF_STAT, 32'h0);
    chk(32'h0, {31'h0, irq});
    $display("conv done, code %h", cs);
  endtask
  task t_abort;
    logic [9:0] r, e, m;
    logic       ok;
    vin <= 10'h29C;
    apb(sac_pkg::OFF_CTRL1, 1'b1, 32'h60);
    apb(sac_pkg::OFF_CTRL0, 1'b1, 32'h3);
    repeat (300) @(posedge pclk);
    apb(sac_pkg::OFF_CTRL0, 1'b1, 32'h1);
    repeat (4) @(posedge pclk);
    apb(sac_pkg::OFF_RES_HI, 1'b0, 32'h0);
    r[9:2] = rd[7:0];
    apb(sac_pkg::OFF_RES_LO, 1'b0, 32'h0);
    r[1:0] = rd[7:6];
    ok = 1'b0;
    for (int k = 1; k < 10; k++) begin
      m = 10'h3FF << (10 - k);
      e = (vin & m) | ({10{vin[10 - k]}} & ~m);
      ok = ok | (r === e);
    end
    chk(32'h1, {31'h0, ok});
    rdc(sac_pkg::OFF_STAT, 32'h0);
    $display("abort done");
  endtask
  task end_sim;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    foreach (cs_l[i]) t_conv(cs_l[i], 10'(i * 146 + 1), i[0]);
    t_abort;
    end_sim;
  end
  initial begin
    #400000;
    n_fail++;
    end_sim;
  end
endmodule // test_sar_adc_conversion_control
